// ===== vector_priority_pkg.sv
// Constants, register map and vector indices for the exception vector priority logic
// Notes on behaviour
// - Select register readable always, writable only when masked
// - Select field bits 7:1 hold vector low byte
// - Out-of-range select promotes the external maskable pin
// - Active promoted source outranks other maskable sources
// - Vector request returns highest valid pending request
// - Vector chosen at fetch time, later winners count
// - Vanished source gives last valid vector seen
// - Never any request gives software interrupt vector
// - Asynchronous wake-up on valid interrupt or nonmaskable pin
// - Three reset request types map to service addresses
// - Resets then opcode trap at fixed top priorities
// - Software, nonmaskable pin, external pin next in order
// - Device sources FFF0 down to FF00, descending priority
// - Test write enable replaces decoder inputs up to the nonmaskable pin with test registers; wake-up still uses the live inputs
package vector_priority_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFS_TEST_CTRL = 8'h15;   // Test control: write enable and bank select
  localparam logic [7:0] OFS_TEST_REQ  = 8'h16;   // Selected request test register
  localparam logic [7:0] OFS_PROMOTE   = 8'h1f;   // Promoted maskable interrupt select
  // Field positions
  localparam int TEST_WREN_BIT = 4;               // Test write enable in control register
  localparam int PSEL_LSB      = 1;               // Select field occupies bits 7:1
  // Reset values
  localparam logic [6:0] PSEL_RESET = 7'h79;      // Points at the external maskable pin vector
  // Vector indices: vector low byte shifted right by one
  localparam logic [6:0] IDX_SYS_RESET = 7'h7f;   // 0xfffe
  localparam logic [6:0] IDX_CLK_MON   = 7'h7e;   // 0xfffc
  localparam logic [6:0] IDX_WATCHDOG  = 7'h7d;   // 0xfffa
  localparam logic [6:0] IDX_TRAP      = 7'h7c;   // 0xfff8
  localparam logic [6:0] IDX_SWI       = 7'h7b;   // 0xfff6
  localparam logic [6:0] IDX_NMI_PIN   = 7'h7a;   // 0xfff4
  localparam logic [6:0] IDX_EXT_PIN   = 7'h79;   // 0xfff2, top of the maskable group
  localparam int         DEV_SOURCES   = 121;     // 0xfff0 down to 0xff00
  localparam logic [7:0] VEC_HIGH      = 8'hff;   // Upper byte of every vector
  localparam logic [7:0] TOP_BANK_MASK = 8'h07;   // Bank F only exposes three test bits
  localparam logic [3:0] TOP_BANK      = 4'hf;
endpackage

// ===== prio_if.sv
// Interface carrying qualified requests and the decoder result
`timescale 1ns/10ps
`default_nettype none
interface prio_if;
  logic [127:0] valid;     // Qualified requests, indexed by vector index
  logic [6:0]   promIdx;   // Index of the promoted maskable source
  logic [6:0]   winIdx;    // Winning index
  logic         found;     // Some request is valid
  modport requester (output valid, output promIdx, input winIdx, input found);
  modport decoder (input valid, input promIdx, output winIdx, output found);
endinterface
`default_nettype wire

// ===== priority_decoder.sv
// Combinational priority decoder with maskable promotion
`timescale 1ns/10ps
`default_nettype none
module priority_decoder
  import vector_priority_pkg::*;
(
  // Requests in, winner out
  prio_if.decoder pif
);
  // Highest set index at or above lowIdx; bit 7 flags a hit
  function automatic logic [7:0] highest(input logic [127:0] v, input int lowIdx);
    logic [7:0] res;
    res = 8'h00;
    for (int i = 0; i < 128; i++) begin
      if (v[i] && i >= lowIdx) begin
        res = {1'b1, 7'(i)};
      end
    end
    return res;
  endfunction

  logic [7:0] topHit;   // Non-maskable group result
  logic [7:0] maskHit;  // Maskable group result

  // Fixed order above the maskable group, then promotion, then descending index
  always_comb begin
    topHit  = highest(pif.valid, int'(IDX_NMI_PIN));
    maskHit = highest({6'h00, pif.valid[int'(IDX_EXT_PIN):0]}, 0);
    pif.found  = topHit[7] | maskHit[7];
    if (topHit[7]) begin
      pif.winIdx = topHit[6:0];
    end else if (pif.valid[pif.promIdx]) begin
      pif.winIdx = pif.promIdx;
    end else begin
      pif.winIdx = maskHit[6:0];
    end
  end
endmodule
`default_nettype wire

// ===== exception_vector_priority_logic.sv
// Exception vector priority logic: request qualification, registers and vector delivery
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module exception_vector_priority_logic
  import vector_priority_pkg::*;
(
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // Register port
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regWrStrobe,
  input  wire logic                   regRdStrobe,
  output logic      [7:0]             regRdData,
  // CPU side
  input  wire logic                   conditionCodeIMask,
  input  wire logic                   conditionCodeXMask,
  input  wire logic                   specialMode,
  input  wire logic                   lowPowerMode,
  input  wire logic                   vectorReq,
  output logic      [15:0]            vectorAddr,
  output logic                        vectorValid,
  output logic                        wakeUp,
  // Reset requests, decoded by the system
  input  wire logic                   powerOnReq,
  input  wire logic                   clockMonitorReq,
  input  wire logic                   watchdogReq,
  // Internal exception requests
  input  wire logic                   trapReq,
  input  wire logic                   softwareInterruptInstruction,
  // Pins, active low, asynchronous
  input  wire logic                   nonmaskablePinRequestN,
  input  wire logic                   extMaskablePinN,
  // Device maskable sources, index 0 is vector 0xff00
  input  wire logic [DEV_SOURCES-1:0] deviceReq
);

  prio_if pif ();

  // Pin synchronisers; first stage feeds only the second
  logic [1:0] nmiSync;          // Nonmaskable pin, active high after inversion
  logic [1:0] extSync;          // External maskable pin, active high
  logic [1:0] next_nmiSync;
  logic [1:0] next_extSync;

  // Register state
  logic [6:0]   promotedIrqSelect;       // Select field of the promotion register
  logic         testWriteEnable;         // Test registers drive the decoder
  logic [3:0]   testBank;                // Selected test register bank
  logic [127:0] requestTestRegister;     // All test banks, flat
  logic [6:0]   next_promotedIrqSelect;
  logic         next_testWriteEnable;
  logic [3:0]   next_testBank;
  logic [127:0] next_requestTestRegister;
  logic [7:0]   next_regRdData;

  // Vector delivery state
  logic [6:0]  lastIdx;        // Last valid winner of this sequence
  logic        everPending;    // A valid request has been seen since reset
  logic [15:0] next_vectorAddr;
  logic        next_vectorValid;
  logic [6:0]  next_lastIdx;
  logic        next_everPending;

  // Combinational helpers
  logic [127:0] rawReq;        // Requests as they arrive
  logic [127:0] effReq;        // After test substitution
  logic [6:0]   bankBase;      // First index of the selected bank
  logic [7:0]   laneMask;      // Implemented bits of the selected bank
  logic         asyncWake;     // Unclocked wake term

  // Pin synchroniser next values
  always_comb begin
    next_nmiSync = {nmiSync[0], ~nonmaskablePinRequestN};
    next_extSync = {extSync[0], ~extMaskablePinN};
  end

  // Pin synchroniser registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nmiSync <= 2'h0;
      extSync <= 2'h0;
    end else begin
      nmiSync <= next_nmiSync;
      extSync <= next_extSync;
    end
  end

  // Gather requests and qualify them against the CPU masks
  always_comb begin
    rawReq = {powerOnReq, clockMonitorReq, watchdogReq,
              trapReq, softwareInterruptInstruction,
              nmiSync[1], extSync[1], deviceReq};
    effReq = rawReq;
    if (testWriteEnable) begin
      // Test bits replace everything up to the nonmaskable pin
      effReq[int'(IDX_NMI_PIN):0] = requestTestRegister[int'(IDX_NMI_PIN):0];
    end
    pif.valid = effReq;
    pif.valid[int'(IDX_NMI_PIN)] = effReq[int'(IDX_NMI_PIN)] & ~conditionCodeXMask;
    pif.valid[int'(IDX_EXT_PIN):0] = effReq[int'(IDX_EXT_PIN):0] & {122{~conditionCodeIMask}};
  end

  // Out-of-range select falls back to the external maskable pin
  always_comb begin
    if (promotedIrqSelect > IDX_EXT_PIN) begin
      pif.promIdx = IDX_EXT_PIN;
    end else begin
      pif.promIdx = promotedIrqSelect;
    end
  end

  priority_decoder u_decoder (
    .pif (pif.decoder)
  );

  // Bank addressing for the test register
  always_comb begin
    bankBase = {testBank, 3'h0};
    laneMask = (testBank == TOP_BANK) ? TOP_BANK_MASK : 8'hff;
  end

  // Register writes and read data
  always_comb begin
    next_promotedIrqSelect   = promotedIrqSelect;
    next_testWriteEnable     = testWriteEnable;
    next_testBank            = testBank;
    next_requestTestRegister = requestTestRegister;
    next_regRdData           = 8'h00;
    if (regWrStrobe) begin
      case (regAddr)
        OFS_PROMOTE: begin
          // Locked while maskable interrupts are enabled
          if (conditionCodeIMask) begin
            next_promotedIrqSelect = regWrData[7:PSEL_LSB];
          end
        end
        OFS_TEST_CTRL: begin
          next_testBank = regWrData[3:0];
          if (specialMode && conditionCodeIMask && conditionCodeXMask) begin
            next_testWriteEnable = regWrData[TEST_WREN_BIT];
            // Requests pending when substitution starts stay until overwritten
            if (regWrData[TEST_WREN_BIT] && !testWriteEnable) begin
              next_requestTestRegister = {5'h00, rawReq[int'(IDX_NMI_PIN):0]};
            end
          end
        end
        OFS_TEST_REQ: begin
          if (specialMode && testWriteEnable && conditionCodeIMask) begin
            next_requestTestRegister[bankBase +: 8] = regWrData & laneMask;
          end
        end
        default: begin
          // Unmapped writes are dropped
        end
      endcase
    end
    if (regRdStrobe) begin
      case (regAddr)
        OFS_PROMOTE: begin
          next_regRdData = {promotedIrqSelect, 1'b0};
        end
        OFS_TEST_CTRL: begin
          next_regRdData = {3'h0, testWriteEnable, testBank};
        end
        OFS_TEST_REQ: begin
          // Normal modes read zero; otherwise test bits or live inputs
          if (specialMode) begin
            next_regRdData = (testWriteEnable ? requestTestRegister[bankBase +: 8]
                                              : rawReq[bankBase +: 8]) & laneMask;
          end
        end
        default: begin
          next_regRdData = 8'h00;
        end
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      promotedIrqSelect   <= PSEL_RESET;
      testWriteEnable     <= 1'b0;
      testBank            <= 4'h0;
      requestTestRegister <= 128'h0;
      regRdData           <= 8'h00;
    end else begin
      promotedIrqSelect   <= next_promotedIrqSelect;
      testWriteEnable     <= next_testWriteEnable;
      testBank            <= next_testBank;
      requestTestRegister <= next_requestTestRegister;
      regRdData           <= next_regRdData;
    end
  end

  // Vector choice happens only on request, so late higher winners take over
  always_comb begin
    next_lastIdx     = lastIdx;
    next_everPending = everPending;
    next_vectorValid = vectorReq;
    next_vectorAddr  = vectorAddr;
    if (pif.found) begin
      // Remember the winner in case the source drops before the fetch
      next_lastIdx     = pif.winIdx;
      next_everPending = 1'b1;
    end
    if (vectorReq) begin
      if (pif.found) begin
        next_vectorAddr = {VEC_HIGH, pif.winIdx, 1'b0};
      end else if (everPending) begin
        next_vectorAddr = {VEC_HIGH, lastIdx, 1'b0};
      end else begin
        next_vectorAddr = {VEC_HIGH, IDX_SWI, 1'b0};
      end
    end
  end

  // Vector delivery flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lastIdx     <= IDX_SWI;
      everPending <= 1'b0;
      vectorValid <= 1'b0;
      vectorAddr  <= {VEC_HIGH, IDX_SYS_RESET, 1'b0};
    end else begin
      lastIdx     <= next_lastIdx;
      everPending <= next_everPending;
      vectorValid <= next_vectorValid;
      vectorAddr  <= next_vectorAddr;
    end
  end

  // Wake-up must work with the clock stopped, so it bypasses every flop
  always_comb begin
    asyncWake = ~nonmaskablePinRequestN
              | (~conditionCodeIMask & (~extMaskablePinN | (|deviceReq)))
              | powerOnReq | clockMonitorReq | watchdogReq;
  end
  assign wakeUp = lowPowerMode & asyncWake;

  // Checks
  property p_promote_locked;
    @(posedge sys_clk) disable iff (!resetn)
    regWrStrobe && regAddr == OFS_PROMOTE && !conditionCodeIMask |=> $stable(promotedIrqSelect);
  endproperty
  a_promote_locked: assert property (p_promote_locked) else $error("select changed while unmasked");

  property p_promote_write;
    @(posedge sys_clk) disable iff (!resetn)
    regWrStrobe && regAddr == OFS_PROMOTE && conditionCodeIMask
      |=> promotedIrqSelect == $past(regWrData[7:1]);
  endproperty
  a_promote_write: assert property (p_promote_write) else $error("select write lost");

  property p_promote_default;
    @(posedge sys_clk) disable iff (!resetn)
    promotedIrqSelect > IDX_EXT_PIN |-> pif.promIdx == IDX_EXT_PIN;
  endproperty
  a_promote_default: assert property (p_promote_default) else $error("bad promotion fallback");

  property p_promoted_wins;
    @(posedge sys_clk) disable iff (!resetn)
    vectorReq && pif.valid[pif.promIdx] && !(|pif.valid[127:122])
      |=> vectorAddr[7:1] == $past(pif.promIdx);
  endproperty
  a_promoted_wins: assert property (p_promoted_wins) else $error("promoted source not chosen");

  property p_answer_next;
    @(posedge sys_clk) disable iff (!resetn)
    vectorReq |=> vectorValid ##1 !vectorValid || $past(vectorReq);
  endproperty
  a_answer_next: assert property (p_answer_next) else $error("vector answer timing wrong");

  property p_sys_reset_top;
    @(posedge sys_clk) disable iff (!resetn)
    vectorReq && powerOnReq |=> vectorAddr == 16'hfffe;
  endproperty
  a_sys_reset_top: assert property (p_sys_reset_top) else $error("system reset not top");

  property p_never_pending;
    @(posedge sys_clk) disable iff (!resetn)
    vectorReq && !everPending && !pif.found |=> vectorAddr == 16'hfff6;
  endproperty
  a_never_pending: assert property (p_never_pending) else $error("default vector wrong");

  property p_last_valid;
    @(posedge sys_clk) disable iff (!resetn)
    vectorReq && everPending && !pif.found |=> vectorAddr[7:1] == $past(lastIdx);
  endproperty
  a_last_valid: assert property (p_last_valid) else $error("last valid vector lost");

  property p_vector_form;
    @(posedge sys_clk) disable iff (!resetn)
    vectorValid |-> vectorAddr[15:8] == 8'hff && !vectorAddr[0];
  endproperty
  a_vector_form: assert property (p_vector_form) else $error("vector not even or high byte wrong");

  property p_test_substitute;
    @(posedge sys_clk) disable iff (!resetn)
    testWriteEnable && !conditionCodeIMask |-> pif.valid[0] == requestTestRegister[0];
  endproperty
  a_test_substitute: assert property (p_test_substitute) else $error("test bits not used");

endmodule
`default_nettype wire

// ===== cpu_vector_master.sv
// CPU-side model that fetches exception vectors from the priority logic
`timescale 1ns/10ps
`default_nettype none
module cpu_vector_master (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Vector port
  output logic             vectorReq,
  input  wire logic [15:0] vectorAddr,
  input  wire logic        vectorValid
);
  // Idle until the bench asks for a fetch
  initial vectorReq = 1'b0;

  // One request pulse after some idle cycles; the answer is sampled in its only valid cycle
  task automatic fetch(input int idle, output logic [15:0] addr, output logic ok);
    while (resetn !== 1'b1) @(posedge sys_clk);
    repeat (idle) @(posedge sys_clk);
    vectorReq <= 1'b1;
    @(posedge sys_clk);
    vectorReq <= 1'b0;
    // Let the edge's register updates land before looking
    #1;
    ok   = (vectorValid === 1'b1);
    addr = vectorAddr;
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the exception vector priority logic
`timescale 1ns/10ps
`default_nettype none
module tb;
  import vector_priority_pkg::*;
  // Clock, reset and register port
  logic         sys_clk            = 1'b0;
  logic         resetn             = 1'b0;
  logic [7:0]   regAddr            = 8'h00;
  logic [7:0]   regWrData          = 8'h00;
  logic         regWrStrobe        = 1'b0;
  logic         regRdStrobe        = 1'b0;
  logic [7:0]   regRdData;
  // CPU status inputs
  logic         conditionCodeIMask = 1'b1;
  logic         conditionCodeXMask = 1'b1;
  logic         specialMode        = 1'b0;
  logic         lowPowerMode       = 1'b0;
  // Named sources, top down: reset, clock monitor, watchdog, trap, swi, nmi pin, ext pin
  logic [6:0]   src                = 7'h00;
  logic [120:0] deviceReq          = '0;
  // Vector port and wake-up
  logic         vectorReq;
  logic [15:0]  vectorAddr;
  logic         vectorValid;
  logic         wakeUp;
  // Bookkeeping
  int           miscompares        = 0;
  int           samplesChecked     = 0;
  int           seed               = 97691;
  logic [6:0]   promSel            = IDX_EXT_PIN;
  logic [6:0]   p;

  // Free-running 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  exception_vector_priority_logic DUT (
    .sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .conditionCodeIMask(conditionCodeIMask), .conditionCodeXMask(conditionCodeXMask),
    .specialMode(specialMode), .lowPowerMode(lowPowerMode), .vectorReq(vectorReq),
    .vectorAddr(vectorAddr), .vectorValid(vectorValid), .wakeUp(wakeUp),
    .powerOnReq(src[6]), .clockMonitorReq(src[5]), .watchdogReq(src[4]), .trapReq(src[3]),
    .softwareInterruptInstruction(src[2]), .nonmaskablePinRequestN(~src[1]),
    .extMaskablePinN(~src[0]), .deviceReq(deviceReq)
  );

  cpu_vector_master cpu (
    .sys_clk(sys_clk), .resetn(resetn), .vectorReq(vectorReq),
    .vectorAddr(vectorAddr), .vectorValid(vectorValid)
  );

  // Counts one comparison and reports a difference at once
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Single-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr     <= a;
    regWrData   <= d;
    regWrStrobe <= 1'b1;
    @(posedge sys_clk);
    regWrStrobe <= 1'b0;
  endtask

  // Single-cycle register read; data is only valid in the following cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr     <= a;
    regRdStrobe <= 1'b1;
    @(posedge sys_clk);
    regRdStrobe <= 1'b0;
    #1;
    chk({8'h00, regRdData}, {8'h00, exp});
  endtask

  // Expected vector from the current request picture; zero-free since every vector starts with ff
  function automatic logic [15:0] expv(input logic [6:0] prom);
    logic [121:0] m;
    logic [6:0]   q;
    m = {src[0], deviceReq} & {122{~conditionCodeIMask}};
    q = (prom > IDX_EXT_PIN) ? IDX_EXT_PIN : prom;
    if (src[6]) return 16'hfffe;
    if (src[5]) return 16'hfffc;
    if (src[4]) return 16'hfffa;
    if (src[3]) return 16'hfff8;
    if (src[2]) return 16'hfff6;
    if (src[1] && !conditionCodeXMask) return 16'hfff4;
    if (m[q]) return {8'hff, q, 1'b0};
    for (int i = 121; i >= 0; i--) if (m[i]) return {8'hff, 7'(i), 1'b0};
    return 16'hfff6;
  endfunction

  // Random device request bits; callers AND two draws for sparse traffic so priority order matters
  function automatic logic [120:0] rnd();
    return 121'({$random(seed), $random(seed), $random(seed), $random(seed)});
  endfunction

  // Fetch a vector; exp of zero means work it out from the live picture
  task automatic vec(input logic [15:0] exp);
    logic [15:0] a;
    logic        ok;
    logic [15:0] e;
    // Pins need two synchroniser stages before they count
    repeat (3) @(posedge sys_clk);
    e = (exp == 16'h0000) ? expv(promSel) : exp;
    cpu.fetch($unsigned($random(seed)) % 3, a, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(a, e);
  endtask

  // Verdict and end of run
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #(8 * 25000);
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    vec(16'hfff6);
    rd(OFS_PROMOTE, 8'hf2);
    rd(8'h40, 8'h00);
    rd(OFS_TEST_REQ, 8'h00);
    $display("test defaults done");
    // Every named source plus device source 120 up, then strip the named ones from the top down
    @(posedge sys_clk);
    conditionCodeIMask <= 1'b0;
    conditionCodeXMask <= 1'b0;
    src                <= 7'h7f;
    deviceReq[120]     <= 1'b1;
    for (int k = 6; k >= 0; k--) begin
      vec(16'h0000);
      @(posedge sys_clk);
      src[k] <= 1'b0;
    end
    vec(16'hfff0);
    $display("test ladder done");
    // Random device traffic, requests held through the fetch
    for (int n = 0; n < 20; n++) begin
      @(posedge sys_clk);
      deviceReq <= rnd() & rnd();
      src[0]    <= 1'($random(seed));
      vec(16'h0000);
    end
    // Source withdrawn before the fetch leaves the last winner
    @(posedge sys_clk);
    src       <= 7'h00;
    deviceReq <= 121'h8;
    repeat (3) @(posedge sys_clk);
    deviceReq <= '0;
    vec(16'hff06);
    $display("test random done");
    // Select writes are ignored while unmasked
    wr(OFS_PROMOTE, 8'h20);
    rd(OFS_PROMOTE, 8'hf2);
    for (int n = 0; n < 12; n++) begin
      p = 7'($unsigned($random(seed)) % 121);
      @(posedge sys_clk);
      conditionCodeIMask <= 1'b1;
      wr(OFS_PROMOTE, {p, 1'b0});
      rd(OFS_PROMOTE, {p, 1'b0});
      @(posedge sys_clk);
      conditionCodeIMask <= 1'b0;
      promSel            <= p;
      deviceReq          <= (rnd() & rnd()) | (121'(1) << p);
      src[0]             <= 1'($random(seed));
      vec(16'h0000);
    end
    // Out-of-range select falls back to the external pin
    @(posedge sys_clk);
    conditionCodeIMask <= 1'b1;
    wr(OFS_PROMOTE, 8'hf4);
    @(posedge sys_clk);
    conditionCodeIMask <= 1'b0;
    promSel            <= 7'h7a;
    src                <= 7'h01;
    deviceReq          <= 121'(1) << 120;
    vec(16'hfff2);
    $display("test promotion done");
    // Test registers stand in for the live inputs
    @(posedge sys_clk);
    src                <= 7'h00;
    deviceReq          <= '0;
    specialMode        <= 1'b1;
    conditionCodeIMask <= 1'b1;
    conditionCodeXMask <= 1'b1;
    // Pin synchronisers must drain first, or the old pin request is copied into the test bits
    repeat (2) @(posedge sys_clk);
    wr(OFS_TEST_CTRL, 8'h10);
    rd(OFS_TEST_CTRL, 8'h10);
    wr(OFS_TEST_REQ, 8'h08);
    rd(OFS_TEST_REQ, 8'h08);
    @(posedge sys_clk);
    conditionCodeIMask <= 1'b0;
    deviceReq          <= 121'(1) << 50;
    vec(16'hff06);
    @(posedge sys_clk);
    conditionCodeIMask <= 1'b1;
    deviceReq          <= '0;
    wr(OFS_TEST_CTRL, 8'h00);
    $display("test register substitution done");
    // Masked nonmaskable pin loses to a device source
    @(posedge sys_clk);
    conditionCodeIMask <= 1'b0;
    src                <= 7'h02;
    deviceReq          <= 121'(1) << 5;
    vec(16'hff0a);
    // Wake-up path in low-power mode, starting from a quiet picture
    @(posedge sys_clk);
    src                <= 7'h00;
    deviceReq          <= '0;
    specialMode        <= 1'b0;
    lowPowerMode       <= 1'b1;
    conditionCodeIMask <= 1'b0;
    conditionCodeXMask <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({15'h0000, wakeUp}, 16'h0000);
    @(posedge sys_clk);
    src <= 7'h02;
    #1;
    chk({15'h0000, wakeUp}, 16'h0001);
    @(posedge sys_clk);
    src          <= 7'h00;
    deviceReq[7] <= 1'b1;
    #1;
    chk({15'h0000, wakeUp}, 16'h0001);
    $display("test wake-up done");
    report_and_stop();
  end
endmodule
`default_nettype wire
